// ---- src/kline_host_consts.vh ----
`ifndef KLINE_HOST_CONSTS_VH
`define KLINE_HOST_CONSTS_VH

// Clock period in picoseconds (250 MHz).
`define CLK_PERIOD_PS 4000
// Least width of the select high pulse that clears a latched fault, in ns (one microsecond).
`define SEL_PULSE_MIN_NS 1000
// Cycles for that pulse, rounded up, at least one.
`define SEL_PULSE_CYC (((`SEL_PULSE_MIN_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Extra cycles the clear pulse is held beyond the minimum.
`define SEL_PULSE_MARGIN 1
// Cycles the line is allowed to settle before echo compare starts.
`define ECHO_SETTLE_CYC 8

`endif

// ---- src/pulse_timer.v ----
`timescale 1ns/1ps
`default_nettype none
`include "kline_host_consts.vh"

// Down counter that reports done once the loaded count has elapsed.
module pulse_timer #(
  parameter WIDTH = 8
) (
  // Clock and control
  input  wire             ref_clk,
  input  wire             rst_n,
  input  wire             clkEn,
  // Load and status
  input  wire             load,
  input  wire [WIDTH-1:0] loadValue,
  output wire             done
);
  reg [WIDTH-1:0] count_reg;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      count_reg <= {WIDTH{1'b0}};
    end else if (clkEn) begin
      if (load) begin
        count_reg <= loadValue;
      end else if (count_reg != {WIDTH{1'b0}}) begin
        count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  assign done = (count_reg == {WIDTH{1'b0}}) && !load;
endmodule
`default_nettype wire

// ---- src/kline_host_ctrl.v ----
`timescale 1ns/1ps
`default_nettype none
`include "kline_host_consts.vh"

// Behaviour
// - Fault clears on a select high pulse of at least one microsecond.
// - Host holds select high whenever it is receiving.
// - Host compares receive against transmit while sending; mismatch is a bus problem.
// - Tying select and transmit together disables short detection.
module kline_host_ctrl #(
  parameter TW = 8
) (
  // Clock, enable and reset
  input  wire ref_clk,
  input  wire rst_n,
  input  wire clkEn,
  // User side
  input  wire txEnable,
  input  wire txData,
  input  wire noShortDetect,
  input  wire faultClearReq,
  output reg  rxData,
  output reg  busy,
  output reg  faultSeen,
  output reg  echoError,
  // Transceiver pins
  input  wire rxPin,
  input  wire fault_n,
  output reg  txPin,
  output reg  select_n
);
  // State codes of the controller.
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_TX    = 3'h1;
  localparam [2:0] ST_CLEAR = 3'h2;
  localparam [2:0] ST_FAULT = 3'h3;

  // Counts are reckoned as integers, then cut to the timer width on purpose.
  localparam integer  CLEAR_CYC_INT  = `SEL_PULSE_CYC + `SEL_PULSE_MARGIN;
  localparam integer  SETTLE_CYC_INT = `ECHO_SETTLE_CYC;
  localparam [TW-1:0] CLEAR_CYC      = CLEAR_CYC_INT[TW-1:0];
  localparam [TW-1:0] SETTLE_CYC     = SETTLE_CYC_INT[TW-1:0];

  // Controller state and the shared timer.
  reg  [2:0]    state_reg;
  reg  [2:0]    state_next;
  reg           timerLoad;
  reg  [TW-1:0] timerValue;
  wire          timerDone;
  // Next values of the registered outputs.
  reg           txPin_next;
  reg           select_next;
  reg           rxData_next;
  reg           busy_next;
  reg           faultSeen_next;
  reg           echoError_next;
  // Decoded conditions.
  wire          faultActive;
  wire          txStart;
  wire          txEdge;
  wire          echoWindow;
  wire          echoMismatch;

  // One timer serves both the echo settle time and the clear pulse.
  pulse_timer #(
    .WIDTH (TW)
  ) u_pulse_timer (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .clkEn     (clkEn),
    .load      (timerLoad),
    .loadValue (timerValue),
    .done      (timerDone)
  );

  // The transceiver shows a latched fault by pulling its open-drain pin low.
  assign faultActive  = !fault_n;
  assign txStart      = (state_reg == ST_IDLE) && txEnable && !faultActive;
  assign txEdge       = (state_reg == ST_TX) && (txPin != txData);
  // The line needs time to follow each edge, so echo is judged only after it.
  assign echoWindow   = (state_reg == ST_TX) && timerDone && !timerLoad;
  assign echoMismatch = (rxPin != txPin);

  // A latched fault always wins over a new or running transmission.
  always @* begin
    state_next = state_reg;
    timerLoad  = 1'b0;
    timerValue = SETTLE_CYC;
    case (state_reg)
      ST_IDLE: begin
        // A fault left over from reception is handled before any transmit.
        if (faultActive) begin
          state_next = ST_FAULT;
        end else if (txEnable) begin
          state_next = ST_TX;
          timerLoad  = 1'b1;
        end
      end
      ST_TX: begin
        if (faultActive) begin
          state_next = ST_FAULT;
        end else if (!txEnable) begin
          // Dropping back to idle raises select before any reception.
          state_next = ST_IDLE;
        end else if (txEdge) begin
          timerLoad = 1'b1;
        end
      end
      ST_FAULT: begin
        // The device latch clears on select high alone; the request ends the wait.
        if (faultClearReq) begin
          state_next = ST_CLEAR;
          timerLoad  = 1'b1;
          timerValue = CLEAR_CYC;
        end
      end
      ST_CLEAR: begin
        // Select stays high for the whole count, so the device latch is released.
        if (timerDone) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Every state but transmit parks in receive mode with the driver off.
  always @* begin
    txPin_next  = 1'b1;
    select_next = 1'b1;
    if (state_next == ST_TX) begin
      txPin_next  = txData;
      // Tied select lets a high bit also drop to receive, so no short is flagged.
      select_next = noShortDetect ? txData : 1'b0;
    end
  end

  // The echo flag holds until the next transmission starts.
  always @* begin
    rxData_next    = rxPin;
    busy_next      = (state_next != ST_IDLE);
    faultSeen_next = (state_next == ST_FAULT) || (state_next == ST_CLEAR);
    echoError_next = echoError;
    if (txStart) begin
      echoError_next = 1'b0;
    end else if (echoWindow && echoMismatch) begin
      echoError_next = 1'b1;
    end
  end

  // Outside reset, every register holds still while the clock enable is low.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  // Reset parks the pins in receive mode with the driver off.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      txPin <= 1'b1;
    end else if (clkEn) begin
      txPin <= txPin_next;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      select_n <= 1'b1;
    end else if (clkEn) begin
      select_n <= select_next;
    end
  end

  // The receive pin is already synchronous, so one register suffices.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      rxData <= 1'b1;
    end else if (clkEn) begin
      rxData <= rxData_next;
    end
  end

  // Busy covers fault and clear so the user holds off new requests.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else if (clkEn) begin
      busy <= busy_next;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      faultSeen <= 1'b0;
    end else if (clkEn) begin
      faultSeen <= faultSeen_next;
    end
  end

  // Sticky, so a short mismatch is not lost between user polls.
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      echoError <= 1'b0;
    end else if (clkEn) begin
      echoError <= echoError_next;
    end
  end
endmodule
`default_nettype wire

// ---- tb/kline_host_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module kline_host_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic busy,
  input wire logic faultSeen,
  input wire logic noShortDetect,
  input wire logic txPin,
  input wire logic select_n
);
  logic [8:0] hiCnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Saturates so a long idle stretch never wraps under the clear width.
  always @(posedge ref_clk) begin
    if (!rst_n || !select_n) hiCnt <= 9'h0;
    else hiCnt <= hiCnt + {8'h0, ~&hiCnt};
  end
  a_idle_select_high: assert property (!busy |-> select_n)
    else $error("select low while idle");
  a_tied_select_tx: assert property (busy && noShortDetect && !faultSeen |-> select_n == txPin)
    else $error("select not tied to transmit");
  a_clear_width_min: assert property ($fell(faultSeen) |-> hiCnt >= 9'h0fa)
    else $error("fault clear pulse too short");
  sequence s_fault_entry;
    $rose(faultSeen);
  endsequence
  sequence s_pins_parked;
    (select_n && txPin) [*8];
  endsequence
  a_fault_pins_parked: assert property (s_fault_entry |-> s_pins_parked)
    else $error("pins not parked after fault");
endmodule
bind kline_host_ctrl kline_host_checker u_kline_host_checker (.ref_clk, .rst_n, .busy,
  .faultSeen, .noShortDetect, .txPin, .select_n);
`default_nettype wire

// ---- tb/kline_xcvr_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module kline_xcvr_model (
  input wire logic txPin,
  input wire logic select_n,
  input wire logic faultEvt,
  input wire logic lineLoad,
  output wire logic rxPin,
  output wire logic fault_n
);
  logic latch = 1'b0;
  int   hiNs  = 0;
  // Open inputs read high through the pull-ups, which keeps the driver off.
  wire  txHigh  = (txPin !== 1'b0);
  wire  selHigh = (select_n !== 1'b0);
  wire  drive = !selHigh && !txHigh && !latch;
  assign rxPin = drive ? 1'b0 : lineLoad;
  assign fault_n = !latch;
  // A select glitch shorter than the minimum leaves the fault set.
  always #1 begin
    hiNs = (selHigh && latch) ? hiNs + 1 : 0;
    if (faultEvt) latch = 1'b1;
    else if (hiNs >= 1000) latch = 1'b0;
  end
endmodule
`default_nettype wire

// ---- tb/test_kline_host_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_kline_host_ctrl;
  logic ref_clk = 1'b0, rst_n = 1'b0, txEnable = 1'b0, txData = 1'b1, noShortDetect = 1'b0;
  logic faultClearReq = 1'b0, faultEvt = 1'b0, lineLoad = 1'b1, clkEn = 1'b1;
  wire  rxData, busy, faultSeen, echoError, rxPin, fault_n, txPin, select_n;
  int   fail_count = 0, checks_done = 0, cyc = 0;
  kline_host_ctrl u_kline_host_ctrl (.ref_clk, .rst_n, .clkEn, .txEnable, .txData,
    .noShortDetect, .faultClearReq, .rxData, .busy, .faultSeen, .echoError, .rxPin,
    .fault_n, .txPin, .select_n);
  kline_xcvr_model u_kline_xcvr_model (.txPin, .select_n, .faultEvt, .lineLoad, .rxPin, .fault_n);
  initial forever #2 ref_clk = ~ref_clk;
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input string name, input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic tx_echo();
    txEnable = 1'b1; txData = 1'b0; step(2);
    chk("select", select_n, 1'b0);
    chk("rx", rxData, 1'b0);
    chk("busy", busy, 1'b1);
    txData = 1'b1; step(12);
    chk("echo", echoError, 1'b0);
    lineLoad = 1'b0; step(12);
    chk("echoBad", echoError, 1'b1);
    txEnable = 1'b0; lineLoad = 1'b1; step(2);
    chk("idleSelect", select_n, 1'b1);
    chk("echoHeld", echoError, 1'b1);
  endtask
  task automatic tied_mode();
    noShortDetect = 1'b1; txEnable = 1'b1; step(2);
    chk("tiedHigh", select_n, 1'b1);
    chk("echoClear", echoError, 1'b0);
    txData = 1'b0; step(2);
    chk("tiedLow", select_n, 1'b0);
    txEnable = 1'b0; noShortDetect = 1'b0; txData = 1'b1; step(2);
  endtask
  task automatic freeze();
    clkEn = 1'b0; txEnable = 1'b1; txData = 1'b0; step(3);
    chk("frozenSelect", select_n, 1'b1);
    chk("frozenBusy", busy, 1'b0);
    clkEn = 1'b1; txEnable = 1'b0; txData = 1'b1; step(2);
  endtask
  task automatic fault_clear();
    txEnable = 1'b1; txData = 1'b0; step(3);
    faultEvt = 1'b1; step(1);
    faultEvt = 1'b0; step(2);
    chk("faultSeen", faultSeen, 1'b1);
    chk("txRelease", txPin, 1'b1);
    txEnable = 1'b0; faultClearReq = 1'b1; step(1);
    faultClearReq = 1'b0;
    for (int i = 0; i < 600 && faultSeen; i++) step(1);
    chk("cleared", faultSeen, 1'b0);
    chk("faultPin", fault_n, 1'b1);
  endtask
  initial begin
    step(10);
    rst_n = 1'b1; step(2);
    tx_echo();
    tied_mode();
    freeze();
    fault_clear();
    test_done();
  end
endmodule
`default_nettype wire
